// ===== src/vrc_regs.vh
// Register map and reset values of the voltage reference control block
`ifndef VRC_REGS_VH
`define VRC_REGS_VH

`define VRC_REF_CTRL_ADDR     8'hd1
`define VRC_REF_CTRL_RESET    8'h00
`define VRC_BIT_SRC_SEL       3
`define VRC_BIT_TEMP_EN       2
`define VRC_BIT_BIAS_EN       1
`define VRC_BIT_BUF_EN        0
`define VRC_WR_MASK           8'h0f

`endif

// ===== src/vrc_reference_control.v
// Reference control register and bias enable combining logic
`timescale 1ns/1ps
`default_nettype none
`include "vrc_regs.vh"

// Operation
// - Bit 3 picks the reference source: 0 the external pin, 1 the supply.
// - Bit 2 turns the temperature sensor on; at 0 it is off and its output floats.
// - The bias generator runs when bit 1 is set or the converter, sensor, oscillator or current DAC is enabled.
// - Bit 0 enables the reference output buffer that drives the reference pin.
// - Bits 7 to 4 read as zero and ignore writes.
// - An enabled current DAC keeps the bias on regardless of the manual bias bit.
module vrc_reference_control (
  // Clock and reset
  input  wire       clk_sys_i,
  input  wire       rst_i,
  // Special function register port
  input  wire [7:0] sfr_addr_i,
  input  wire       sfr_wr_i,
  input  wire [7:0] sfr_wdata_i,
  output wire [7:0] sfr_rdata_o,
  output wire       sfr_hit_o,
  // Enables of bias consumers
  input  wire       adc_enable_i,
  input  wire       osc_enable_i,
  input  wire       current_dac_enable_i,
  // Analog controls
  output wire       reference_source_select_o,
  output wire       temp_sensor_enable_o,
  output wire       temp_sensor_hiz_o,
  output wire       bias_generator_enable_o,
  output wire       reference_buffer_enable_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Register geometry
  localparam integer      DATA_W      = 8;

  localparam integer      CTRL_W      = 4;

  localparam integer      CONS_W      = 5;

  // Register address, reset image and writable bits
  localparam [DATA_W-1:0] REG_ADDR    = `VRC_REF_CTRL_ADDR;

  localparam [DATA_W-1:0] RESET_VALUE = `VRC_REF_CTRL_RESET;

  localparam [DATA_W-1:0] WRITE_MASK  = `VRC_WR_MASK;

  // Field positions
  localparam integer      POS_SRC     = `VRC_BIT_SRC_SEL;

  localparam integer      POS_TEMP    = `VRC_BIT_TEMP_EN;

  localparam integer      POS_BIAS    = `VRC_BIT_BIAS_EN;

  localparam integer      POS_BUF     = `VRC_BIT_BUF_EN;

  // Slots of the bias consumer vector
  localparam integer      CONS_MANUAL = 0;

  localparam integer      CONS_ADC    = 1;

  localparam integer      CONS_TEMP   = 2;

  localparam integer      CONS_OSC    = 3;

  localparam integer      CONS_DAC    = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Storage and decode
  reg  [CTRL_W-1:0] ctrl_q;

  wire [CTRL_W-1:0] ctrl_d;

  wire [CTRL_W-1:0] bit_wr_en_w;

  wire [CTRL_W-1:0] wdata_ctrl_w;

  wire              sel_w;

  wire              wr_hit_w;

  // Read path
  wire [DATA_W-1:0] rdata_raw_w;

  wire [DATA_W-1:0] rdata_w;

  // Field views
  wire              src_sel_w;

  wire              temp_en_w;

  wire              bias_manual_w;

  wire              buf_en_w;

  // Bias combining
  wire [CONS_W-1:0] consumer_w;

  wire              bias_any_w;

  genvar            gi;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  assign sel_w = (sfr_addr_i == REG_ADDR);

  // Write only when this register is addressed
  assign wr_hit_w = sfr_wr_i & sel_w;

  // Only the low nibble carries control bits
  assign wdata_ctrl_w = sfr_wdata_i[CTRL_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Per-bit write enables and next values
  generate
    for (gi = 0; gi < CTRL_W; gi = gi + 1) begin : g_ctrl_bit

      // Bits outside the mask never load
      assign bit_wr_en_w[gi] = wr_hit_w & WRITE_MASK[gi];

      assign ctrl_d[gi] = bit_wr_en_w[gi] ? wdata_ctrl_w[gi] : ctrl_q[gi];

    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Control storage
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= RESET_VALUE[CTRL_W-1:0];
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data assembly
  generate
    for (gi = 0; gi < DATA_W; gi = gi + 1) begin : g_rd_bit

      if (gi < CTRL_W) begin : g_live
        assign rdata_raw_w[gi] = ctrl_q[gi];
      end else begin : g_unused
        // Unused positions always read zero
        assign rdata_raw_w[gi] = 1'b0;
      end

    end
  endgenerate

  assign rdata_w = rdata_raw_w & WRITE_MASK;

  // Other addresses read zero
  assign sfr_rdata_o = sel_w ?
                       rdata_w :
                       {DATA_W{1'b0}};

  assign sfr_hit_o = sel_w;

  ////////////////////////////////////////////////////////////////////////////
  // Field views of the register
  assign src_sel_w = ctrl_q[POS_SRC];

  assign temp_en_w = ctrl_q[POS_TEMP];

  assign bias_manual_w = ctrl_q[POS_BIAS];

  assign buf_en_w = ctrl_q[POS_BUF];

  ////////////////////////////////////////////////////////////////////////////
  // Reference source select, 1 picks the supply
  assign reference_source_select_o = src_sel_w;

  ////////////////////////////////////////////////////////////////////////////
  // Temperature sensor control
  assign temp_sensor_enable_o = temp_en_w;

  // Sensor output floats while it is off
  assign temp_sensor_hiz_o = ~temp_en_w;

  ////////////////////////////////////////////////////////////////////////////
  // Reference output buffer
  assign reference_buffer_enable_o = buf_en_w;

  ////////////////////////////////////////////////////////////////////////////
  // Bias consumers
  assign consumer_w[CONS_MANUAL] = bias_manual_w;

  assign consumer_w[CONS_ADC] = adc_enable_i;

  assign consumer_w[CONS_TEMP] = temp_en_w;

  assign consumer_w[CONS_OSC] = osc_enable_i;

  assign consumer_w[CONS_DAC] = current_dac_enable_i;

  // Any consumer forces the bias on
  assign bias_any_w = |consumer_w;

  assign bias_generator_enable_o = bias_any_w;

endmodule
`default_nettype wire

// ===== test/vrc_checker.sv
// Reference control checker
`timescale 1ns/1ps
`default_nettype none
module vrc_checker (
  input wire       clk_sys_i,
  input wire       rst_i,
  input wire       sfr_wr_i,
  input wire [7:0] sfr_addr_i,
  input wire [7:0] sfr_wdata_i,
  input wire [7:0] sfr_rdata_o,
  input wire       adc_enable_i,
  input wire       osc_enable_i,
  input wire       current_dac_enable_i,
  input wire       reference_source_select_o,
  input wire       temp_sensor_enable_o,
  input wire       temp_sensor_hiz_o,
  input wire       bias_generator_enable_o,
  input wire       reference_buffer_enable_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence s_wr;
    sfr_wr_i && sfr_addr_i == 8'hd1;
  endsequence
  sequence s_no_wr;
    !(sfr_wr_i && sfr_addr_i == 8'hd1);
  endsequence
  a_upper_read_zero: assert property (sfr_rdata_o[7:4] == 4'h0) else $error("upper bits");
  a_bias_consumer_or: assert property (adc_enable_i | osc_enable_i | current_dac_enable_i | temp_sensor_enable_o
    |-> bias_generator_enable_o) else $error("bias off");
  a_buffer_write: assert property (s_wr |=> reference_buffer_enable_o == $past(sfr_wdata_i[0])) else $error("buf");
  a_source_write: assert property (s_wr |=> reference_source_select_o == $past(sfr_wdata_i[3])) else $error("src");
  a_sensor_write: assert property (s_wr |=> temp_sensor_enable_o == $past(sfr_wdata_i[2])
    && temp_sensor_hiz_o == !$past(sfr_wdata_i[2])) else $error("sensor");
  a_dac_forces_bias: assert property (current_dac_enable_i |-> bias_generator_enable_o) else $error("dac bias");
  a_other_addr_zero: assert property (sfr_addr_i != 8'hd1 |-> sfr_rdata_o == 8'h00) else $error("other addr");
  a_hold_no_write: assert property (s_no_wr |=> $stable({reference_source_select_o, temp_sensor_enable_o,
    reference_buffer_enable_o})) else $error("hold");
  a_reset_clears: assert property (@(posedge clk_sys_i) disable iff (1'b0) rst_i |-> !reference_source_select_o
    && !temp_sensor_enable_o && temp_sensor_hiz_o && !reference_buffer_enable_o) else $error("reset");
endmodule
bind vrc_reference_control vrc_checker u_chk(.*);
`default_nettype wire

// ===== test/vrc_reference_control_test.sv
// Reference control testbench
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,b) begin total_checks++; if ((a) !== (b)) begin miscompares++; $display("Error %0t: value mismatch", $time); end end
module vrc_reference_control_test;
  logic       clk_sys_i    = 1'b0;
  logic       rst_i        = 1'b1;
  logic       wr           = 1'b0;
  logic [2:0] en           = 3'h0;
  logic [7:0] ad           = 8'h00;
  logic [7:0] wd           = 8'h00;
  logic [7:0] rd;
  logic [7:0] d;
  logic       hit;
  logic       s;
  logic       t;
  logic       z;
  logic       b;
  logic       f;
  int         miscompares  = 0;
  int         total_checks = 0;
  int         cyc          = 0;

  vrc_reference_control u_dut (
    .clk_sys_i                 (clk_sys_i),
    .rst_i                     (rst_i),
    .sfr_addr_i                (ad),
    .sfr_wr_i                  (wr),
    .sfr_wdata_i               (wd),
    .sfr_rdata_o               (rd),
    .sfr_hit_o                 (hit),
    .adc_enable_i              (en[0]),
    .osc_enable_i              (en[1]),
    .current_dac_enable_i      (en[2]),
    .reference_source_select_o (s),
    .temp_sensor_enable_o      (t),
    .temp_sensor_hiz_o         (z),
    .bias_generator_enable_o   (b),
    .reference_buffer_enable_o (f)
  );

  always #4 clk_sys_i = ~clk_sys_i;

  // Cycle ceiling
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc > 500) begin
      $display("Error %0t: timeout", $time);
      miscompares++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    #1;
    ad = a;
    wd = v;
    wr = 1'b1;
    @(posedge clk_sys_i);
    #1;
    wr = 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_sys_i);
    #1;
    ad = a;
    @(posedge clk_sys_i);
    v = rd;
  endtask

  initial begin
    repeat (5) @(posedge clk_sys_i);
    #1;
    rst_i = 1'b0;
    rd_reg(8'hd1, d);
    `CHK(d, 8'h00)
    `CHK({s, t, z, b, f}, 5'b00100)
    $display("test reset done");

    for (int i = 0; i < 16; i++) begin
      wr_reg(8'hd1, {4'ha, i[3:0]});
      rd_reg(8'hd1, d);
      `CHK(d, {4'h0, i[3:0]})
      `CHK(hit, 1'b1)
      `CHK(s, i[3])
      `CHK({t, z}, {i[2], ~i[2]})
      `CHK(f, i[0])
      `CHK(b, i[1] | i[2])
    end
    $display("test fields done");

    wr_reg(8'h55, 8'h00);
    rd_reg(8'h55, d);
    `CHK(d, 8'h00)
    `CHK(hit, 1'b0)
    rd_reg(8'hd1, d);
    `CHK(d, 8'h0f)
    $display("test address done");

    wr_reg(8'hd1, 8'h00);
    for (int j = 0; j < 8; j++) begin
      @(posedge clk_sys_i);
      #1;
      en = j[2:0];
      @(posedge clk_sys_i);
      `CHK(b, (j != 0))
    end
    @(posedge clk_sys_i);
    #1;
    en = 3'h0;
    $display("test bias done");

    wr_reg(8'hd1, 8'h0f);
    @(posedge clk_sys_i);
    #1;
    rst_i = 1'b1;
    @(posedge clk_sys_i);
    #1;
    `CHK({s, t, z, f}, 4'b0010)
    `CHK(b, 1'b0)
    rst_i = 1'b0;
    rd_reg(8'hd1, d);
    `CHK(d, 8'h00)
    $display("test mid reset done");

    stop_test();
  end
endmodule
`default_nettype wire
